/* File: afecr_pkg.sv */
// Shared constants and types for the analog front end configuration bank
package afecr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_OFS_CAL = 16'h0701;
  localparam logic [15:0] IDX_REF_SEL = 16'h18A6;
  localparam logic [15:0] IDX_CM_BUF = 16'h18E3;
  localparam logic [15:0] IDX_TDIODE = 16'h18E6;
  localparam logic [15:0] IDX_COUPLING = 16'h1908;
  localparam logic [15:0] IDX_FULL_SCALE = 16'h1910;

  // Bus geometry
  localparam int ADDR_W_MIN = 15;
  localparam int IDX_LSB = 2;
  localparam int REG_W = 8;
  localparam int DATA_W = 32;

  // Reset values
  localparam logic [7:0] RST_OFS_CAL = 8'h06;
  localparam logic [0:0] RST_REF_SEL = 1'h0;
  localparam logic [0:0] RST_CM_EN = 1'h0;
  localparam logic [5:0] RST_CM_SET = 6'h00;
  localparam logic [7:0] RST_TDIODE = 8'h00;
  localparam logic [0:0] RST_DC_CPL = 1'h0;
  localparam logic [3:0] RST_FULL_SCALE = 4'hD;

  // Offset calibration codes
  localparam logic [7:0] OFS_CAL_DISABLE = 8'h06;
  localparam logic [7:0] OFS_CAL_ENABLE = 8'h86;

  // Field positions
  localparam int POS_REF_SEL = 0;
  localparam int POS_CM_EN = 6;
  localparam int POS_CM_SET_LSB = 0;
  localparam int CM_SET_W = 6;
  localparam int POS_DC_CPL = 2;
  localparam int POS_FS_LSB = 0;
  localparam int FS_W = 4;

  // Temperature diode code layout
  localparam logic [7:0] TD_CENTRAL_BASE = 8'h00;
  localparam logic [7:0] TD_CORE_BASE = 8'h40;
  localparam logic [7:0] TD_PIN_MASK = 8'h03;

  // Reference pin routing of the diode
  typedef enum logic [1:0] {
    PIN_HIGHZ = 2'b00,
    PIN_DIODE_1X = 2'b01,
    PIN_DIODE_20X = 2'b10,
    PIN_GROUND = 2'b11
  } afecr_pin_t;

  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_DONE = 2'b10
  } afecr_state_t;

endpackage : afecr_pkg

/* File: afecr_diode_route.sv */
// Decoder of the temperature diode routing code
`timescale 1ns/1ns
`default_nettype none

module afecr_diode_route (
  input wire logic [7:0] code,
  output logic coreSel,
  output afecr_pkg::afecr_pin_t pinMode,
  output logic codeValid
);

  logic [7:0] base;

  always_comb begin
    base = code & ~afecr_pkg::TD_PIN_MASK;
    coreSel = 1'b0;
    pinMode = afecr_pkg::PIN_HIGHZ;
    codeValid = 1'b0;
    if (base == afecr_pkg::TD_CENTRAL_BASE) begin
      // Central diode, four pin outcomes
      coreSel = 1'b0;
      pinMode = afecr_pkg::afecr_pin_t'(code[1:0]);
      codeValid = 1'b1;
    end else if (base == afecr_pkg::TD_CORE_BASE) begin
      // Converter core diode, same order
      coreSel = 1'b1;
      pinMode = afecr_pkg::afecr_pin_t'(code[1:0]);
      codeValid = 1'b1;
    end
  end

endmodule : afecr_diode_route

`default_nettype wire

/* File: afecr_regs.sv */
// Analog front end configuration register bank with APB slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none

module afecr_regs #(
  parameter int ADDR_W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] offsetCalCode,
  output logic offsetCalEn,
  output logic offsetCalCodeValid,
  output logic extRefSel,
  output logic commonModeVoltageBufEn,
  output logic [5:0] commonModeVoltageSetting,
  output logic diodeCoreSel,
  output logic [1:0] refPinMode,
  output logic diodeCodeValid,
  output logic dcCouplingEn,
  output logic [3:0] fullScaleSel
);

  // Elaboration check on address width
  if (ADDR_W < afecr_pkg::ADDR_W_MIN) begin : gChkAddr
    $error("afecr_regs: ADDR_W too small for the register map");
  end

  typedef struct packed {
    afecr_pkg::afecr_state_t st;
    logic [31:0] rdata;
    logic err;
    logic [7:0] ofsCal;
    logic calEn;
    logic calValid;
    logic refSel;
    logic cmEn;
    logic [5:0] cmSet;
    logic [7:0] tdiode;
    logic tdCore;
    logic [1:0] tdPin;
    logic tdValid;
    logic dcCpl;
    logic [3:0] fsSel;
  } afecr_regs_t;

  afecr_regs_t state_r;
  afecr_regs_t state_nxt;

  // Address decode
  logic [ADDR_W-1:0] idxFull;
  logic [15:0] idx;
  logic aligned;
  logic hitOfs;
  logic hitRef;
  logic hitCm;
  logic hitTd;
  logic hitCpl;
  logic hitFs;
  logic mapped;

  // Diode decoder result
  logic decCore;
  afecr_pkg::afecr_pin_t decPin;
  logic decValid;

  logic wrEn;
  logic [7:0] wByte;
  logic [7:0] tdNext;

  assign idxFull = paddr >> afecr_pkg::IDX_LSB;
  assign idx = 16'(idxFull);
  assign aligned = (paddr[1:0] == 2'h0);

  assign hitOfs = aligned && (idx == afecr_pkg::IDX_OFS_CAL);
  assign hitRef = aligned && (idx == afecr_pkg::IDX_REF_SEL);
  assign hitCm = aligned && (idx == afecr_pkg::IDX_CM_BUF);
  assign hitTd = aligned && (idx == afecr_pkg::IDX_TDIODE);
  assign hitCpl = aligned && (idx == afecr_pkg::IDX_COUPLING);
  assign hitFs = aligned && (idx == afecr_pkg::IDX_FULL_SCALE);

  assign mapped = hitOfs | hitRef | hitCm | hitTd | hitCpl | hitFs;

  // Write commits at the completing edge, low lane only
  assign wrEn = (state_r.st == afecr_pkg::ST_ACCESS) && psel && penable && pwrite && mapped
                && pstrb[0];
  assign wByte = pwdata[7:0];

  // Diode code to be stored, decoded apart from the state copy
  assign tdNext = (wrEn && hitTd) ? wByte : state_r.tdiode;

  // Read data for the addressed register; unused bits zero
  function automatic logic [31:0] readMux(
    input afecr_regs_t s,
    input logic hOfs,
    input logic hRef,
    input logic hCm,
    input logic hTd,
    input logic hCpl,
    input logic hFs
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    if (hOfs) begin
      d[7:0] = s.ofsCal;
    end
    if (hRef) begin
      d[afecr_pkg::POS_REF_SEL] = s.refSel;
    end
    if (hCm) begin
      d[afecr_pkg::POS_CM_EN] = s.cmEn;
      d[afecr_pkg::POS_CM_SET_LSB +: afecr_pkg::CM_SET_W] = s.cmSet;
    end
    if (hTd) begin
      d[7:0] = s.tdiode;
    end
    if (hCpl) begin
      d[afecr_pkg::POS_DC_CPL] = s.dcCpl;
    end
    if (hFs) begin
      d[afecr_pkg::POS_FS_LSB +: afecr_pkg::FS_W] = s.fsSel;
    end
    return d;
  endfunction : readMux

  afecr_diode_route uDiode (
    .code(tdNext),
    .coreSel(decCore),
    .pinMode(decPin),
    .codeValid(decValid)
  );

  always_comb begin
    state_nxt = state_r;

    // Bus slave sequencing
    case (state_r.st)
      afecr_pkg::ST_IDLE: begin
        if (psel && !penable) begin
          state_nxt.st = afecr_pkg::ST_ACCESS;
          state_nxt.rdata = pwrite ? 32'h0000_0000 :
            readMux(state_r, hitOfs, hitRef, hitCm, hitTd, hitCpl, hitFs);
          state_nxt.err = !mapped;
        end
      end
      afecr_pkg::ST_ACCESS: begin
        if (psel && penable) begin
          state_nxt.st = afecr_pkg::ST_DONE;
        end else if (!psel) begin
          state_nxt.st = afecr_pkg::ST_IDLE;
        end
      end
      afecr_pkg::ST_DONE: begin
        state_nxt.rdata = 32'h0000_0000;
        state_nxt.err = 1'b0;
        if (psel && !penable) begin
          // Back-to-back setup
          state_nxt.st = afecr_pkg::ST_ACCESS;
          state_nxt.rdata = pwrite ? 32'h0000_0000 :
            readMux(state_r, hitOfs, hitRef, hitCm, hitTd, hitCpl, hitFs);
          state_nxt.err = !mapped;
        end else begin
          state_nxt.st = afecr_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt.st = afecr_pkg::ST_IDLE;
      end
    endcase

    // Register writes; reserved bits are never stored
    if (wrEn) begin
      if (hitOfs) begin
        state_nxt.ofsCal = wByte;
      end
      if (hitRef) begin
        state_nxt.refSel = wByte[afecr_pkg::POS_REF_SEL];
      end
      if (hitCm) begin
        state_nxt.cmEn = wByte[afecr_pkg::POS_CM_EN];
        state_nxt.cmSet = wByte[afecr_pkg::POS_CM_SET_LSB +: afecr_pkg::CM_SET_W];
      end
      if (hitTd) begin
        state_nxt.tdiode = wByte;
      end
      if (hitCpl) begin
        state_nxt.dcCpl = wByte[afecr_pkg::POS_DC_CPL];
      end
      if (hitFs) begin
        state_nxt.fsSel = wByte[afecr_pkg::POS_FS_LSB +: afecr_pkg::FS_W];
      end
    end

    // Calibration runs only on the enable code
    state_nxt.calEn = (state_nxt.ofsCal == afecr_pkg::OFS_CAL_ENABLE);
    state_nxt.calValid = state_nxt.calEn ||
      (state_nxt.ofsCal == afecr_pkg::OFS_CAL_DISABLE);

    // Diode routing follows the stored code
    state_nxt.tdCore = decCore;
    state_nxt.tdPin = decPin;
    state_nxt.tdValid = decValid;

    // Reset to documented values
    if (!nrst) begin
      state_nxt.st = afecr_pkg::ST_IDLE;
      state_nxt.rdata = 32'h0000_0000;
      state_nxt.err = 1'b0;
      state_nxt.ofsCal = afecr_pkg::RST_OFS_CAL;
      state_nxt.calEn = 1'b0;
      state_nxt.calValid = 1'b1;
      state_nxt.refSel = afecr_pkg::RST_REF_SEL;
      state_nxt.cmEn = afecr_pkg::RST_CM_EN;
      state_nxt.cmSet = afecr_pkg::RST_CM_SET;
      state_nxt.tdiode = afecr_pkg::RST_TDIODE;
      state_nxt.tdCore = 1'b0;
      state_nxt.tdPin = afecr_pkg::PIN_HIGHZ;
      state_nxt.tdValid = 1'b1;
      state_nxt.dcCpl = afecr_pkg::RST_DC_CPL;
      state_nxt.fsSel = afecr_pkg::RST_FULL_SCALE;
    end
  end

  always_ff @(posedge clk_sys) begin
    state_r <= state_nxt;
  end

  // Bus answers: zero wait states
  assign pready = (state_r.st == afecr_pkg::ST_ACCESS) && psel && penable;
  assign pslverr = pready && state_r.err;
  assign prdata = state_r.rdata;

  // Analog control outputs
  assign offsetCalCode = state_r.ofsCal;
  assign offsetCalEn = state_r.calEn;
  assign offsetCalCodeValid = state_r.calValid;
  assign extRefSel = state_r.refSel;
  assign commonModeVoltageBufEn = state_r.cmEn;
  assign commonModeVoltageSetting = state_r.cmSet;
  assign diodeCoreSel = state_r.tdCore;
  assign refPinMode = state_r.tdPin;
  assign diodeCodeValid = state_r.tdValid;
  assign dcCouplingEn = state_r.dcCpl;
  assign fullScaleSel = state_r.fsSel;

endmodule : afecr_regs

`default_nettype wire

/* File: afecr_regs_checker.sv */
// Port assertions for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module afecr_regs_checker #(
  parameter int ADDR_W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] offsetCalCode,
  input wire logic offsetCalEn,
  input wire logic offsetCalCodeValid,
  input wire logic commonModeVoltageBufEn,
  input wire logic [5:0] commonModeVoltageSetting,
  input wire logic diodeCoreSel,
  input wire logic [1:0] refPinMode,
  input wire logic diodeCodeValid,
  input wire logic dcCouplingEn,
  input wire logic [3:0] fullScaleSel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  zero_wait_a: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("no ready in first access cycle");
  ofs_enable_a: assert property (offsetCalEn == (offsetCalCode == 8'h86))
    else $error("offset enable wrong");
  ofs_valid_a: assert property (
    offsetCalCodeValid == (offsetCalCode inside {8'h06, 8'h86}))
    else $error("offset valid wrong");
  cm_enable_a: assert property (wr && paddr == 16'h638C
    |=> commonModeVoltageBufEn == $past(pwdata[6]))
    else $error("buffer enable not written");
  cm_setting_a: assert property (wr && paddr == 16'h638C
    |=> commonModeVoltageSetting == $past(pwdata[5:0]))
    else $error("buffer setting not written");
  diode_route_a: assert property (wr && paddr == 16'h6398
    && pwdata[7:0] inside {[8'h00:8'h03], [8'h40:8'h43]}
    |=> {diodeCoreSel, refPinMode, diodeCodeValid} == {$past(pwdata[6]), $past(pwdata[1:0]), 1'h1})
    else $error("diode route wrong");
  coupling_a: assert property (wr && paddr == 16'h6420
    |=> dcCouplingEn == $past(pwdata[2]))
    else $error("coupling bit not written");
  full_scale_a: assert property (wr && paddr == 16'h6440
    |=> fullScaleSel == $past(pwdata[3:0]))
    else $error("full scale not written");
  reserved_read_a: assert property (
    psel && penable && pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  reset_value_a: assert property (disable iff (1'h0) nrst && !$past(nrst)
    |-> fullScaleSel == 4'hD && offsetCalCode == 8'h06 && !dcCouplingEn)
    else $error("bad reset value");
endmodule : afecr_regs_checker
bind afecr_regs afecr_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .offsetCalCode, .offsetCalEn,
  .offsetCalCodeValid, .commonModeVoltageBufEn, .commonModeVoltageSetting, .diodeCoreSel,
  .refPinMode, .diodeCodeValid, .dcCouplingEn, .fullScaleSel);
`default_nettype wire

/* File: afecr_testbench.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic offsetCalEn, offsetCalCodeValid, extRefSel, commonModeVoltageBufEn;
  logic diodeCoreSel, diodeCodeValid, dcCouplingEn;
  logic [1:0] refPinMode;
  logic [3:0] pstrb, fullScaleSel;
  logic [5:0] commonModeVoltageSetting;
  logic [7:0] offsetCalCode;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, checked;
  logic chain;
  localparam logic [15:0] ADR [6] = '{afecr_pkg::IDX_OFS_CAL << 2, afecr_pkg::IDX_REF_SEL << 2,
    afecr_pkg::IDX_CM_BUF << 2, afecr_pkg::IDX_TDIODE << 2, afecr_pkg::IDX_COUPLING << 2,
    afecr_pkg::IDX_FULL_SCALE << 2};
  localparam logic [7:0] RSTV [6] = '{8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0D};
  localparam logic [7:0] ONES [6] = '{8'hFF, 8'h01, 8'h7F, 8'hFF, 8'h04, 8'h0F};
  afecr_regs #(.ADDR_W(16)) dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .offsetCalCode, .offsetCalEn, .offsetCalCodeValid,
    .extRefSel, .commonModeVoltageBufEn, .commonModeVoltageSetting, .diodeCoreSel, .refPinMode,
    .diodeCodeValid, .dcCouplingEn, .fullScaleSel);
  task automatic final_report();
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic keep = 1'h0);
    int n;
    n = 0;
    if (!chain) @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        chk("pready", 32'h1, {31'h0, pready});
        final_report();
      end
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    chain = keep;
    if (!keep) begin
      psel <= 1'h0;
      penable <= 1'h0;
      @(negedge clk_sys);
    end
  endtask : xfer
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    chain = 1'h0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'h1;
    @(negedge clk_sys);
    chk("cm buffer", 32'h0, {commonModeVoltageBufEn, commonModeVoltageSetting});
    chk("diode", 32'h1, {diodeCoreSel, refPinMode, diodeCodeValid});
    chk("offset", 32'h1, {offsetCalEn, offsetCalCodeValid});
    chk("ext ref", 32'h0, {31'h0, extRefSel});
    for (int i = 0; i < 6; i++) begin
      xfer(1'h0, ADR[i], 32'h0, 4'hF);
      chk("reset read", {24'h0, RSTV[i]}, rd);
    end
    for (int i = 0; i < 6; i++) begin
      xfer(1'h1, ADR[i], 32'hFFFFFFFF, 4'hF);
      xfer(1'h0, ADR[i], 32'h0, 4'hF);
      chk("ones read", {24'h0, ONES[i]}, rd);
    end
    chk("coupling", 32'h1, {31'h0, dcCouplingEn});
    chk("full scale", 32'hF, {28'h0, fullScaleSel});
    chk("ext ref", 32'h1, {31'h0, extRefSel});
    chk("diode illegal", 32'h0, {diodeCoreSel, refPinMode, diodeCodeValid});
    chk("offset illegal", 32'h0, {offsetCalEn, offsetCalCodeValid});
    xfer(1'h1, ADR[5], 32'h3, 4'h0);
    xfer(1'h1, ADR[5] + 16'h1, 32'h3, 4'hF);
    chk("misaligned error", 32'h1, {31'h0, err});
    xfer(1'h0, 16'h0004, 32'h0, 4'hF);
    chk("unmapped read", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    chk("full scale kept", 32'hF, {28'h0, fullScaleSel});
    xfer(1'h1, ADR[5], 32'h3, 4'hF);
    chk("full scale", 32'h3, {28'h0, fullScaleSel});
    xfer(1'h1, ADR[4], 32'hFB, 4'hF);
    chk("coupling", 32'h0, {31'h0, dcCouplingEn});
    xfer(1'h1, ADR[2], 32'h55, 4'hF, 1'h1);
    xfer(1'h0, ADR[2], 32'h0, 4'hF);
    chk("cm read", 32'h55, rd);
    chk("cm buffer", 32'h55, {commonModeVoltageBufEn, commonModeVoltageSetting});
    for (int i = 0; i < 2; i++) begin
      xfer(1'h1, ADR[0], i ? 32'h06 : 32'h86, 4'hF);
      chk("offset", {30'h0, i == 0, 1'h1}, {offsetCalEn, offsetCalCodeValid});
    end
    for (int i = 0; i < 8; i++) begin
      xfer(1'h1, ADR[3], {25'h0, i[2], 4'h0, i[1:0]}, 4'hF);
      chk("diode", {i[2], i[1:0], 1'h1}, {diodeCoreSel, refPinMode, diodeCodeValid});
    end
    @(posedge clk_sys);
    nrst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    @(negedge clk_sys);
    chk("reset cm", 32'h0, {commonModeVoltageBufEn, commonModeVoltageSetting});
    chk("reset diode", 32'h1, {diodeCoreSel, refPinMode, diodeCodeValid});
    chk("reset full scale", 32'hD, {28'h0, fullScaleSel});
    chk("reset ext ref", 32'h0, {31'h0, extRefSel});
    xfer(1'h0, ADR[5], 32'h0, 4'hF);
    chk("reset read", 32'hD, rd);
    final_report();
  end
endmodule : testbench
`default_nettype wire
